// file: shared/pbg_pkg.sv
// shared constants, register map and sequence helper for the self-test block
package pbg_pkg;
  localparam int ADDR_W = 10;
  localparam logic [7:0] IDX_BYTE_COUNT = 8'h71;
  localparam logic [7:0] IDX_ERROR_STATUS = 8'h72;
  localparam logic [7:0] IDX_PACKET_LENGTH = 8'h7B;
  localparam logic [7:0] IDX_GAP_LENGTH = 8'h7C;
  localparam logic [7:0] IDX_CONTROL = 8'h80;
  localparam logic [7:0] IDX_PACKET_COUNT = 8'h81;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h82;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h83;
  localparam logic [15:0] RST_PACKET_LENGTH = 16'h05DC;
  localparam logic [7:0] RST_GAP_LENGTH = 8'h7D;
  localparam logic [7:0] RST_ERROR_COUNT = 8'h00;
  localparam int LOCK_BIT = 0;
  localparam int CLEAR_BIT = 1;
  localparam int BYTE_OVF_BIT = 9;
  localparam int PKT_OVF_BIT = 10;
  localparam int CTRL_WRAP_BIT = 0;
  localparam int CTRL_GEN_EN_BIT = 1;
  localparam int IRQ_BYTE_OVF = 0;
  localparam int IRQ_PKT_OVF = 1;
  localparam int IRQ_TX_DONE = 2;
  localparam int IRQ_RX_DONE = 3;
  localparam int IRQ_W = 4;
  localparam logic [3:0] PREAMBLE_NIBBLE = 4'h5;
  localparam int PREAMBLE_NIBBLES = 13;
  localparam logic [7:0] SFD_BYTE = 8'hD5;
  localparam int LEAD_FIVES = PREAMBLE_NIBBLES + 1;
  localparam int GAP_BYTES_PER_STEP = 4;
  localparam int NIBBLES_PER_BYTE = 2;
  localparam logic [6:0] PRBS_SEED = 7'h7F;

  // next prbs7 byte, first bit in msb; the byte's low 7 bits are the new state
  function automatic logic [7:0] prbs7_byte(input logic [6:0] seed);
    logic [6:0] s;
    logic [7:0] o;
    s = seed;
    o = 8'h00;
    for (int i = 7; i >= 0; i--)
    begin
      o[i] = s[6] ^ s[5];
      s = {s[5:0], o[i]};
    end
    return o;
  endfunction : prbs7_byte
endpackage : pbg_pkg

// file: core/pbg_counter.sv
// live test counter with wrap or saturate and an overflow pulse
`timescale 1ns/1ps
module pbg_counter #(
  parameter int W = 16
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic inc_in,
  input wire logic clear_in,
  input wire logic wrap_in,
  output logic [W-1:0] count_out,
  output logic overflow_out
);
  typedef struct packed {
    logic [W-1:0] count;
  } pbg_cnt_s;
  pbg_cnt_s q, d;
  logic at_max;

  assign at_max = &q.count;
  assign overflow_out = inc_in && at_max;
  assign count_out = q.count;

  // clear restarts from zero, an increment in the same cycle still counts
  always_comb
  begin
    d = q;
    if (clear_in)
      d.count = inc_in ? W'(1) : '0;
    else if (inc_in && !(at_max && !wrap_in)) // RL5
      d.count = q.count + W'(1);
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      q <= '0;
    else
      q <= d;
  end
endmodule : pbg_counter

// file: core/pbg_gen.sv
// test packet generator: lead-in, prbs payload, idle gap, nibble wide
`timescale 1ns/1ps
module pbg_gen #(
  parameter int LEN_W = 16,
  parameter int GAP_W = 8
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic enable_in,
  input wire logic [LEN_W-1:0] test_packet_length_in,
  input wire logic [GAP_W-1:0] inter_packet_gap_length_in,
  output logic [3:0] tx_data_out,
  output logic tx_en_out,
  output logic packet_done_out
);
  localparam int CW = (LEN_W + 1 > GAP_W + 3) ? LEN_W + 1 : GAP_W + 3;
  typedef enum logic [2:0] {GEN_IDLE, GEN_LEAD, GEN_SFD, GEN_DATA, GEN_GAP} pbg_gen_e;
  typedef struct packed {
    pbg_gen_e state;
    logic [CW-1:0] cnt;
    logic [6:0] lfsr;
    logic [7:0] cur;
    logic [3:0] txd;
    logic txen;
    logic done;
  } pbg_gen_s;
  pbg_gen_s q, d;
  logic [CW-1:0] data_total;
  logic [CW-1:0] gap_total;
  logic [7:0] nxt;

  assign data_total = CW'(test_packet_length_in) * CW'(pbg_pkg::NIBBLES_PER_BYTE); // RL8
  assign gap_total = CW'(inter_packet_gap_length_in) * CW'(pbg_pkg::GAP_BYTES_PER_STEP * 2); // RL10 RL11
  assign nxt = pbg_pkg::prbs7_byte(q.lfsr);
  assign tx_data_out = q.txd;
  assign tx_en_out = q.txen;
  assign packet_done_out = q.done;

  // sequence state machine, outputs registered one nibble ahead
  always_comb
  begin
    d = q;
    d.done = 1'b0;
    unique case (q.state)
      GEN_IDLE, GEN_GAP:
      begin
        d.txen = 1'b0;
        d.txd = 4'h0;
        if (q.state == GEN_GAP && q.cnt != gap_total)
          d.cnt = q.cnt + CW'(1);
        else if (enable_in)
        begin
          d.state = GEN_LEAD;
          d.cnt = CW'(1);
          d.txen = 1'b1;
          d.txd = pbg_pkg::PREAMBLE_NIBBLE; // RL9
        end
        else
          d.state = GEN_IDLE;
      end
      GEN_LEAD:
      begin
        if (q.cnt != CW'(pbg_pkg::LEAD_FIVES))
          d.cnt = q.cnt + CW'(1);
        else
        begin
          d.state = GEN_SFD;
          d.txd = pbg_pkg::SFD_BYTE[7:4]; // RL9
        end
      end
      GEN_SFD, GEN_DATA:
      begin
        if (q.state == GEN_SFD ? data_total == '0 : q.cnt == data_total)
        begin
          d.done = 1'b1;
          d.txen = 1'b0;
          d.txd = 4'h0;
          d.cnt = CW'(1);
          d.state = (gap_total == '0) ? GEN_IDLE : GEN_GAP; // RL10
        end
        else if (q.state == GEN_DATA && q.cnt[0])
        begin
          d.txd = q.cur[7:4];
          d.cnt = q.cnt + CW'(1);
        end
        else
        begin
          d.state = GEN_DATA;
          d.cur = nxt;
          d.lfsr = nxt[6:0];
          d.txd = nxt[3:0];
          d.cnt = (q.state == GEN_SFD) ? CW'(1) : q.cnt + CW'(1);
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      q <= '{state: GEN_IDLE, cnt: '0, lfsr: pbg_pkg::PRBS_SEED, cur: 8'h00, txd: 4'h0, txen: 1'b0, done: 1'b0};
    else
      q <= d;
  end
endmodule : pbg_gen

// file: core/pbg_bist.sv
// self-test top: register slave, prbs checker, counters and snapshots
//
// What this block does
// RL1: packet counter overflow sets read-only bit 10 until a clear write.
// RL2: byte counter overflow sets read-only bit 9 until a clear write.
// RL3: bits 7:0 show errored received bytes, zero after reset.
// RL4: writing bit 0 or bit 1 freezes the error count shown.
// RL5: with wrap select zero the error count stops at 0xFF.
// RL6: writing bit 0 locks all counters for reading, clears nothing.
// RL7: writing bit 1 locks and clears counters and both overflow flags.
// RL8: every packet carries the payload length from the length register, reset 1500.
// RL9: each packet starts with 13 nibbles of 0x5 then delimiter 0xD5.
// RL10: an idle gap from an 8-bit field, default 0x7D, separates packets.
// RL11: gap length in bytes is four times the field value.
// RL12: 16-bit received byte count, locked by writes, saturates at 0xFFFF with wrap select zero and wraps when it is set.
// RL13: live counters run on after a lock; snapshots hold until the next.
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ps
module pbg_bist #(
  parameter int LEN_W = 16,
  parameter int GAP_W = 8,
  parameter int BYTE_W = 16,
  parameter int ERR_W = 8,
  parameter int PKT_W = 16
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [pbg_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic irq_out,
  output logic [3:0] tx_data_out,
  output logic tx_en_out,
  input wire logic [3:0] rx_data_in,
  input wire logic rx_dv_in
);
  typedef enum logic [2:0] {
    CHK_IDLE,
    CHK_LEAD,
    CHK_LOW,
    CHK_HIGH,
    CHK_DRAIN
  } pbg_chk_e;

  typedef struct packed {
    pbg_chk_e chk;
    logic [3:0] low_nib;
    logic [7:0] prev;
    logic seeded;
    logic byte_inc;
    logic err_inc;
    logic pkt_inc;
    logic [LEN_W-1:0] pkt_len;
    logic [GAP_W-1:0] gap;
    logic wrap;
    logic gen_en;
    logic [BYTE_W-1:0] snap_byte;
    logic [ERR_W-1:0] snap_err;
    logic [PKT_W-1:0] snap_pkt;
    logic byte_ovf;
    logic pkt_ovf;
    logic [pbg_pkg::IRQ_W-1:0] irq_status;
    logic [pbg_pkg::IRQ_W-1:0] irq_mask;
    logic irq;
    logic wait_n;
    logic [31:0] rdata;
    logic lock;
    logic clear;
  } pbg_top_s;

  pbg_top_s q, d;

  logic [BYTE_W-1:0] byte_cnt;
  logic [ERR_W-1:0] err_cnt;
  logic [PKT_W-1:0] pkt_cnt;
  logic byte_ovf_p;
  logic err_ovf_p;
  logic pkt_ovf_p;
  logic gen_done;
  logic access;
  logic wr_take;
  logic [7:0] rx_byte;
  logic [7:0] expect_byte;
  logic [pbg_pkg::IRQ_W-1:0] irq_set;
  logic [pbg_pkg::IRQ_W-1:0] irq_w1c;

  // register index hit, word aligned only
  function automatic logic hit(
    input logic [pbg_pkg::ADDR_W-1:0] addr,
    input logic [7:0] idx
  );
    return (addr[pbg_pkg::ADDR_W-1:2] == idx) && (addr[1:0] == 2'b00);
  endfunction : hit

  // generator drives the transmit nibbles
  pbg_gen #(
    .LEN_W(LEN_W),
    .GAP_W(GAP_W)
  ) u_gen (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .enable_in(q.gen_en),
    .test_packet_length_in(q.pkt_len),
    .inter_packet_gap_length_in(q.gap),
    .tx_data_out(tx_data_out),
    .tx_en_out(tx_en_out),
    .packet_done_out(gen_done)
  );

  // live received byte counter
  pbg_counter #(
    .W(BYTE_W)
  ) u_byte_cnt (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .inc_in(q.byte_inc),
    .clear_in(q.clear), // RL7
    .wrap_in(q.wrap), // RL12
    .count_out(byte_cnt),
    .overflow_out(byte_ovf_p)
  );

  // live errored byte counter
  pbg_counter #(
    .W(ERR_W)
  ) u_err_cnt (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .inc_in(q.err_inc),
    .clear_in(q.clear), // RL7
    .wrap_in(q.wrap), // RL5
    .count_out(err_cnt),
    .overflow_out(err_ovf_p)
  );

  // live received packet counter
  pbg_counter #(
    .W(PKT_W)
  ) u_pkt_cnt (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .inc_in(q.pkt_inc),
    .clear_in(q.clear), // RL7
    .wrap_in(q.wrap),
    .count_out(pkt_cnt),
    .overflow_out(pkt_ovf_p)
  );

  // bus handshake: one wait cycle, then the answer
  assign access = avs_read_in || avs_write_in;
  assign wr_take = avs_write_in && !q.wait_n;
  assign rx_byte = {rx_data_in, q.low_nib};
  assign expect_byte = pbg_pkg::prbs7_byte(q.prev[6:0]);

  // events into the sticky interrupt bits
  always_comb
  begin
    irq_set = '0;
    irq_set[pbg_pkg::IRQ_BYTE_OVF] = byte_ovf_p;
    irq_set[pbg_pkg::IRQ_PKT_OVF] = pkt_ovf_p;
    irq_set[pbg_pkg::IRQ_TX_DONE] = gen_done;
    irq_set[pbg_pkg::IRQ_RX_DONE] = q.pkt_inc;
    irq_w1c = '0;
    if (wr_take && hit(avs_address_in, pbg_pkg::IDX_IRQ_STATUS) && avs_byteenable_in[0])
      irq_w1c = avs_writedata_in[pbg_pkg::IRQ_W-1:0];
  end

  // next state of the whole block
  always_comb
  begin
    d = q;
    d.byte_inc = 1'b0;
    d.err_inc = 1'b0;
    d.pkt_inc = 1'b0;
    d.lock = 1'b0;
    d.clear = 1'b0;

    // checker: find lead-in, pair nibbles low first, compare payload
    unique case (q.chk)
      CHK_IDLE:
      begin
        if (rx_dv_in && rx_data_in == pbg_pkg::PREAMBLE_NIBBLE)
          d.chk = CHK_LEAD;
      end
      CHK_LEAD:
      begin
        if (!rx_dv_in)
          d.chk = CHK_IDLE;
        else if (rx_data_in == pbg_pkg::SFD_BYTE[7:4])
        begin
          d.chk = CHK_LOW;
          d.seeded = 1'b0;
        end
        else if (rx_data_in != pbg_pkg::PREAMBLE_NIBBLE)
          d.chk = CHK_DRAIN;
      end
      CHK_LOW:
      begin
        if (!rx_dv_in)
        begin
          d.chk = CHK_IDLE;
          d.pkt_inc = 1'b1;
        end
        else
        begin
          d.low_nib = rx_data_in;
          d.chk = CHK_HIGH;
        end
      end
      CHK_HIGH:
      begin
        if (!rx_dv_in)
        begin
          d.chk = CHK_IDLE;
          d.pkt_inc = 1'b1;
        end
        else
        begin
          d.chk = CHK_LOW;
          d.byte_inc = 1'b1; // RL12
          d.err_inc = q.seeded && (rx_byte != expect_byte); // RL3
          d.prev = rx_byte;
          d.seeded = 1'b1;
        end
      end
      CHK_DRAIN:
      begin
        if (!rx_dv_in)
          d.chk = CHK_IDLE;
      end
    endcase

    // snapshots follow only lock pulses, live counters keep running
    if (q.lock)
    begin
      d.snap_byte = byte_cnt; // RL12 RL13
      d.snap_err = err_cnt; // RL4 RL13
      d.snap_pkt = pkt_cnt; // RL6 RL13
    end

    // overflow flags: sticky, cleared with the counters, set wins
    d.byte_ovf = (q.byte_ovf && !q.clear) || byte_ovf_p; // RL2 RL7
    d.pkt_ovf = (q.pkt_ovf && !q.clear) || pkt_ovf_p; // RL1 RL7

    // interrupt status, write one to clear, new event wins
    d.irq_status = (q.irq_status & ~irq_w1c) | irq_set;
    d.irq = |(d.irq_status & q.irq_mask);

    // register writes land at the edge that ends the answer cycle, with waitrequest low
    if (wr_take)
    begin
      if (hit(avs_address_in, pbg_pkg::IDX_ERROR_STATUS) && avs_byteenable_in[0])
      begin
        d.lock = avs_writedata_in[pbg_pkg::LOCK_BIT] || avs_writedata_in[pbg_pkg::CLEAR_BIT]; // RL4 RL6
        d.clear = avs_writedata_in[pbg_pkg::CLEAR_BIT]; // RL7
      end
      if (hit(avs_address_in, pbg_pkg::IDX_PACKET_LENGTH))
      begin
        if (avs_byteenable_in[0])
          d.pkt_len[7:0] = avs_writedata_in[7:0]; // RL8
        if (avs_byteenable_in[1])
          d.pkt_len[15:8] = avs_writedata_in[15:8]; // RL8
      end
      if (hit(avs_address_in, pbg_pkg::IDX_GAP_LENGTH) && avs_byteenable_in[0])
        d.gap = avs_writedata_in[GAP_W-1:0]; // RL10
      if (hit(avs_address_in, pbg_pkg::IDX_CONTROL) && avs_byteenable_in[0])
      begin
        d.wrap = avs_writedata_in[pbg_pkg::CTRL_WRAP_BIT];
        d.gen_en = avs_writedata_in[pbg_pkg::CTRL_GEN_EN_BIT];
      end
      if (hit(avs_address_in, pbg_pkg::IDX_IRQ_MASK) && avs_byteenable_in[0])
        d.irq_mask = avs_writedata_in[pbg_pkg::IRQ_W-1:0];
    end

    // wait cycle handshake and read data registered for the answer
    d.wait_n = !(access && q.wait_n);
    d.rdata = 32'h0000_0000;
    if (avs_read_in && q.wait_n)
    begin
      if (hit(avs_address_in, pbg_pkg::IDX_BYTE_COUNT))
        d.rdata[BYTE_W-1:0] = q.snap_byte; // RL12
      if (hit(avs_address_in, pbg_pkg::IDX_ERROR_STATUS))
      begin
        d.rdata[ERR_W-1:0] = q.snap_err; // RL3
        d.rdata[pbg_pkg::BYTE_OVF_BIT] = q.byte_ovf; // RL2
        d.rdata[pbg_pkg::PKT_OVF_BIT] = q.pkt_ovf; // RL1
      end
      if (hit(avs_address_in, pbg_pkg::IDX_PACKET_LENGTH))
        d.rdata[LEN_W-1:0] = q.pkt_len;
      if (hit(avs_address_in, pbg_pkg::IDX_GAP_LENGTH))
        d.rdata[GAP_W-1:0] = q.gap;
      if (hit(avs_address_in, pbg_pkg::IDX_CONTROL))
      begin
        d.rdata[pbg_pkg::CTRL_WRAP_BIT] = q.wrap;
        d.rdata[pbg_pkg::CTRL_GEN_EN_BIT] = q.gen_en;
      end
      if (hit(avs_address_in, pbg_pkg::IDX_PACKET_COUNT))
        d.rdata[PKT_W-1:0] = q.snap_pkt;
      if (hit(avs_address_in, pbg_pkg::IDX_IRQ_STATUS))
        d.rdata[pbg_pkg::IRQ_W-1:0] = q.irq_status;
      if (hit(avs_address_in, pbg_pkg::IDX_IRQ_MASK))
        d.rdata[pbg_pkg::IRQ_W-1:0] = q.irq_mask;
    end
  end

  // the error counter has no flag of its own; its wrap is silent
  logic unused_err_ovf;
  assign unused_err_ovf = err_ovf_p;

  // outputs straight from the state register
  assign avs_readdata_out = q.rdata;
  assign avs_waitrequest_out = q.wait_n;
  assign irq_out = q.irq;

  // state register, constants only under reset
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      q <= '0;
      q.chk <= CHK_IDLE;
      q.pkt_len <= pbg_pkg::RST_PACKET_LENGTH; // RL8
      q.gap <= pbg_pkg::RST_GAP_LENGTH; // RL10
      q.snap_err <= pbg_pkg::RST_ERROR_COUNT; // RL3
      q.wait_n <= 1'b1;
    end
    else
      q <= d;
  end
endmodule : pbg_bist

// file: testbench/pbg_bist_asserts.sv
// port checker for the self-test block, bound to its top
`timescale 1ns/1ps
module pbg_bist_asserts (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [pbg_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic irq_out,
  input wire logic [3:0] tx_data_out,
  input wire logic tx_en_out,
  input wire logic [3:0] rx_data_in,
  input wire logic rx_dv_in
);
  localparam logic [9:0] ADDR_STAT = {pbg_pkg::IDX_ERROR_STATUS, 2'b00};
  localparam logic [9:0] ADDR_LEN = {pbg_pkg::IDX_PACKET_LENGTH, 2'b00};
  localparam logic [9:0] ADDR_GAP = {pbg_pkg::IDX_GAP_LENGTH, 2'b00};
  logic [17:0] nib_q;
  logic [11:0] idle_q;
  logic [15:0] len_q;
  logic [7:0] gap_q;
  logic wr_ok;
  logic rd_ok;
  default clocking dcb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  // accepted bus transfers
  assign wr_ok = avs_write_in && !avs_waitrequest_out;
  assign rd_ok = avs_read_in && !avs_waitrequest_out;
  // run lengths of the nibble stream, shadows of length and gap
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      nib_q <= '0;
      idle_q <= 12'hFFF;
      len_q <= pbg_pkg::RST_PACKET_LENGTH;
      gap_q <= pbg_pkg::RST_GAP_LENGTH;
    end
    else
    begin
      nib_q <= tx_en_out ? nib_q + 18'd1 : 18'd0;
      idle_q <= tx_en_out ? 12'd0 : idle_q + {11'd0, idle_q != 12'hFFF};
      if (wr_ok && avs_address_in == ADDR_LEN)
        len_q <= avs_writedata_in[15:0];
      if (wr_ok && avs_address_in == ADDR_GAP)
        gap_q <= avs_writedata_in[7:0];
    end
  end
  bus_stands_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low longer than one cycle");
  bus_answer_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("request not answered in one cycle");
  status_rsvd_a: assert property (rd_ok && avs_address_in == ADDR_STAT
    |-> avs_readdata_out[31:11] == '0 && !avs_readdata_out[8])
    else $error("reserved status bits not zero");
  gap_rsvd_a: assert property (rd_ok && avs_address_in == ADDR_GAP |-> avs_readdata_out[31:8] == '0)
    else $error("reserved gap bits not zero");
  lead_fives_a: assert property (tx_en_out && nib_q < 18'd14 |-> tx_data_out == pbg_pkg::PREAMBLE_NIBBLE)
    else $error("lead-in nibble wrong");
  sfd_nibble_a: assert property (tx_en_out && nib_q == 18'd14 |-> tx_data_out == 4'hD)
    else $error("delimiter nibble wrong");
  frame_length_a: assert property ($fell(tx_en_out) |-> nib_q == {1'b0, len_q, 1'b0} + 18'd15)
    else $error("frame length wrong");
  gap_minimum_a: assert property ($rose(tx_en_out)
    |-> idle_q >= ((gap_q == 8'h00) ? 12'd1 : {1'b0, gap_q, 3'b000}))
    else $error("gap too short");
  cover property ($fell(tx_en_out));
  cover property (rd_ok && avs_address_in == ADDR_STAT);
  cover property ($rose(irq_out));
endmodule : pbg_bist_asserts

bind pbg_bist pbg_bist_asserts u_pbg_bist_asserts (.clk_in(clk_in), .rst_in(rst_in),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
  .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out), .irq_out(irq_out),
  .tx_data_out(tx_data_out), .tx_en_out(tx_en_out), .rx_data_in(rx_data_in), .rx_dv_in(rx_dv_in));

// file: testbench/tb_top.sv
// self-checking bench for the self-test block
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %0t: got %0h exp %0h", $time, g, e); end end
module tb_top;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [9:0] avs_address_in = '0;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = '0;
  logic [3:0] avs_byteenable_in = 4'hF;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic irq_out;
  logic [3:0] tx_data_out;
  logic tx_en_out;
  logic [3:0] rx_data_in = '0;
  logic rx_dv_in = 1'b0;
  logic loop = 1'b0;
  logic prev_en = 1'b0;
  logic [31:0] rd;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  int seed = 32'ha78d;
  int e_bytes = 0;
  int e_pkts = 0;
  int e_errs = 0;
  int cur_len = 0;
  int gap, h, g, ob;

  // counters narrowed so both overflow flags are reached within the run
  pbg_bist #(.BYTE_W(9), .PKT_W(4)) u_pbg_bist (.clk_in(clk_in), .rst_in(rst_in),
    .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .irq_out(irq_out), .tx_data_out(tx_data_out),
    .tx_en_out(tx_en_out), .rx_data_in(rx_data_in), .rx_dv_in(rx_dv_in));

  // 50 MHz clock
  always #10 clk_in = ~clk_in;

  // loopback, frame tally and hang guard
  always @(posedge clk_in)
  begin
    cycles++;
    if (loop)
    begin
      rx_data_in <= tx_data_out;
      rx_dv_in <= tx_en_out;
      if (prev_en && !tx_en_out)
      begin
        e_pkts++;
        e_bytes += cur_len;
      end
    end
    prev_en = tx_en_out;
    if (cycles == 60000)
    begin
      failures++;
      complete_run();
    end
  end

  // verdict and end of run
  task automatic complete_run();
    if (failures == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run

  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [15:0] wd);
    avs_address_in <= {idx, 2'b00};
    avs_write_in <= wr;
    avs_read_in <= !wr;
    avs_writedata_in <= {16'h0000, wd};
    do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
    rd = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge clk_in);
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [15:0] wd);
    bus(1'b1, idx, wd);
  endtask : wr

  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 16'h0000);
    `CHK(rd, exp)
  endtask : rdc

  // length of a run of tx_en at one level
  task automatic run(input logic v, output int n);
    n = 0;
    while (tx_en_out === v)
    begin
      n++;
      @(posedge clk_in);
    end
  endtask : run

  // zero state repeats zero; every other pair of these bytes is an error
  function automatic int exp_err(input logic [7:0] p, input logic [7:0] c);
    return (p == 8'h00 && c == 8'h00) ? 0 : 1;
  endfunction : exp_err

  task automatic nib(input logic [3:0] v);
    rx_data_in <= v;
    rx_dv_in <= 1'b1;
    @(posedge clk_in);
  endtask : nib

  // lead-in then n bytes of zero or all-ones, low nibble first
  task automatic send_frame(input int n, input bit all_ff);
    logic [7:0] b;
    logic [7:0] p;
    p = 8'h00;
    for (int i = 0; i < 15; i++)
      nib(i < 14 ? 4'h5 : 4'hD);
    for (int i = 0; i < n; i++)
    begin
      b = (all_ff || $random(seed) % 2) ? 8'hFF : 8'h00;
      if (i > 0)
        e_errs += exp_err(p, b);
      nib(b[3:0]);
      nib(b[7:4]);
      p = b;
    end
    rx_dv_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    e_bytes += n;
    e_pkts++;
  endtask : send_frame

  // main sequence
  initial
  begin
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    rdc(pbg_pkg::IDX_PACKET_LENGTH, 32'h000005DC);
    rdc(pbg_pkg::IDX_GAP_LENGTH, 32'h0000007D);
    rdc(pbg_pkg::IDX_ERROR_STATUS, 32'h00000000);
    rdc(8'h00, 32'h00000000);
    for (int i = 0; i < 3; i++)
    begin
      cur_len = (i == 0) ? 0 : (i == 1) ? 1 + ($random(seed) & 31) : 2;
      gap = (i == 0) ? 0 : (i == 1) ? 1 + ($random(seed) & 7) : 255;
      wr(pbg_pkg::IDX_PACKET_LENGTH, 16'(cur_len));
      wr(pbg_pkg::IDX_GAP_LENGTH, 16'(gap));
      loop <= 1'b1;
      wr(pbg_pkg::IDX_CONTROL, 16'h0002);
      run(1'b0, h);
      run(1'b1, h);
      `CHK(h, 15 + 2 * cur_len)
      run(1'b0, g);
      `CHK(g, (gap == 0) ? 1 : 8 * gap)
      wr(pbg_pkg::IDX_CONTROL, 16'h0000);
      repeat (2200) @(posedge clk_in);
    end
    loop <= 1'b0;
    wr(pbg_pkg::IDX_ERROR_STATUS, 16'h0001);
    rdc(pbg_pkg::IDX_BYTE_COUNT, e_bytes);
    rdc(pbg_pkg::IDX_PACKET_COUNT, e_pkts);
    rdc(pbg_pkg::IDX_ERROR_STATUS, 32'h00000000);
    ob = e_bytes;
    send_frame(8, 1'b0);
    rdc(pbg_pkg::IDX_BYTE_COUNT, ob);
    wr(pbg_pkg::IDX_ERROR_STATUS, 16'h0002);
    rdc(pbg_pkg::IDX_BYTE_COUNT, e_bytes);
    rdc(pbg_pkg::IDX_ERROR_STATUS, e_errs);
    rdc(pbg_pkg::IDX_PACKET_COUNT, e_pkts);
    wr(pbg_pkg::IDX_ERROR_STATUS, 16'h0001);
    rdc(pbg_pkg::IDX_BYTE_COUNT, 32'h00000000);
    rdc(pbg_pkg::IDX_ERROR_STATUS, 32'h00000000);
    for (int m = 0; m < 2; m++)
    begin
      wr(pbg_pkg::IDX_CONTROL, 16'(m));
      wr(pbg_pkg::IDX_ERROR_STATUS, 16'h0002);
      send_frame(301, 1'b1);
      wr(pbg_pkg::IDX_ERROR_STATUS, 16'h0001);
      rdc(pbg_pkg::IDX_ERROR_STATUS, (m == 1) ? 32'h0000002C : 32'h000000FF);
      rdc(pbg_pkg::IDX_BYTE_COUNT, 32'h0000012D);
    end
    // narrowed byte and packet counters run past their range in wrap mode
    send_frame(301, 1'b1);
    repeat (14) send_frame(0, 1'b0);
    wr(pbg_pkg::IDX_ERROR_STATUS, 16'h0001);
    rdc(pbg_pkg::IDX_ERROR_STATUS, 32'h00000658);
    wr(pbg_pkg::IDX_ERROR_STATUS, 16'h0002);
    rdc(pbg_pkg::IDX_ERROR_STATUS, 32'h00000058);
    // interrupt raised, masked and cleared
    wr(pbg_pkg::IDX_IRQ_STATUS, 16'h000F);
    wr(pbg_pkg::IDX_IRQ_MASK, 16'h0008);
    @(posedge clk_in);
    `CHK(irq_out, 1'b0)
    send_frame(2, 1'b0);
    rdc(pbg_pkg::IDX_IRQ_STATUS, 32'h00000008);
    `CHK(irq_out, 1'b1)
    wr(pbg_pkg::IDX_IRQ_MASK, 16'h0000);
    @(posedge clk_in);
    `CHK(irq_out, 1'b0)
    wr(pbg_pkg::IDX_IRQ_MASK, 16'h0008);
    @(posedge clk_in);
    `CHK(irq_out, 1'b1)
    wr(pbg_pkg::IDX_IRQ_STATUS, 16'h0008);
    @(posedge clk_in);
    `CHK(irq_out, 1'b0)
    complete_run();
  end
endmodule : tb_top
